// >>> pbrt_pkg.sv
package pbrt_pkg;
   // variant encoding
   localparam logic [1:0] VAR_LEVEL  = 2'h0;
   localparam logic [1:0] VAR_FIXED2 = 2'h1;
   localparam logic [1:0] VAR_FIXED1 = 2'h2;

   localparam longint CLK_HZ          = 64'd100000000;
   localparam longint HOLD_LONG_MS    = 64'd12500;
   localparam longint HOLD_SHORT_MS   = 64'd7500;
   localparam longint PULSE_MS        = 64'd400;
   localparam longint POWER_UP_US     = 64'd300;
   localparam longint ZERO_DETECT_US  = 64'd150;

   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] HOLD_LONG_CYC  = CNT_W'(HOLD_LONG_MS * CLK_HZ / 64'd1000);
   localparam logic [CNT_W-1:0] HOLD_SHORT_CYC = CNT_W'(HOLD_SHORT_MS * CLK_HZ / 64'd1000);
   localparam logic [CNT_W-1:0] PULSE_CYC      = CNT_W'(PULSE_MS * CLK_HZ / 64'd1000);
   localparam logic [CNT_W-1:0] POWER_UP_CYC   = CNT_W'((POWER_UP_US * CLK_HZ + 64'd999999) / 64'd1000000);
   localparam logic [CNT_W-1:0] ZERO_DETECT_CYC = CNT_W'(ZERO_DETECT_US * CLK_HZ / 64'd1000000);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   typedef enum logic [1:0] {
      ST_POWER_UP = 2'h0,
      ST_ARMED    = 2'h1,
      ST_ASSERT   = 2'h3,
      ST_SPENT    = 2'h2
   } ctl_state_t;
endpackage : pbrt_pkg

// >>> pin_sync.sv
`timescale 1ns/1ns
module pin_sync
   import pbrt_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   input  wire logic reset_value_i,
   output logic      level_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic init;
   } sync_t;

   sync_t st;
   sync_t next_st;

   // a change counts once the second and third stages agree
   always_comb begin
      next_st      = st;
      next_st.s1   = pin_i;
      next_st.s2   = st.s1;
      next_st.s3   = st.s2;
      next_st.init = 1'b1;
      if (!st.init) begin
         // start the compare stages at the idle level so no false change follows reset
         next_st.s2  = reset_value_i;
         next_st.s3  = reset_value_i;
         next_st.lvl = reset_value_i;
      end else if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_o = st.lvl;
endmodule : pin_sync

// >>> push_button_reset_timer.sv
`timescale 1ns/1ns
module push_button_reset_timer
   import pbrt_pkg::*;
#(
   parameter logic [1:0]       VARIANT         = VAR_FIXED2,
   parameter logic [CNT_W-1:0] HOLD_LONG_CYCLES  = HOLD_LONG_CYC,
   parameter logic [CNT_W-1:0] HOLD_SHORT_CYCLES = HOLD_SHORT_CYC,
   parameter logic [CNT_W-1:0] PULSE_CYCLES      = PULSE_CYC
)(
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic button_input_a_i,
   input  wire logic button_input_b_i,
   input  wire logic hold_time_select_i,
   output logic      reset_n_out_o,
   output logic      reset_n_oe_o
);
   typedef struct packed {
      ctl_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic             sel_high;
      logic             oe;
   } ctl_t;

   ctl_t st;
   ctl_t next_st;
   logic a_lvl;
   logic b_lvl;
   logic sel_lvl;
   logic pressed;
   logic [CNT_W-1:0] hold_cyc;

   pin_sync u_sync_a (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .pin_i         (button_input_a_i),
      .reset_value_i (1'b1),
      .level_o       (a_lvl)
   );

   pin_sync u_sync_b (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .pin_i         (button_input_b_i),
      .reset_value_i (1'b1),
      .level_o       (b_lvl)
   );

   // the select pin is a board level too and must not reach the state logic raw
   pin_sync u_sync_sel (
      .ref_clk_i     (ref_clk_i),
      .rst_i         (rst_i),
      .pin_i         (hold_time_select_i),
      .reset_value_i (1'b0),
      .level_o       (sel_lvl)
   );

   // the single-input variant looks only at input a
   always_comb begin
      if (VARIANT == VAR_FIXED1) begin
         pressed = !a_lvl;
      end else begin
         pressed = !a_lvl && !b_lvl;
      end
   end

   // zero hold still needs the detection delay
   always_comb begin
      if (VARIANT == VAR_LEVEL) begin
         hold_cyc = st.sel_high ? HOLD_LONG_CYCLES : HOLD_SHORT_CYCLES;
      end else begin
         hold_cyc = st.sel_high ? ZERO_DETECT_CYC : HOLD_SHORT_CYCLES;
      end
   end

   always_comb begin
      next_st = st;
      case (st.state)
         ST_POWER_UP: begin
            next_st.cnt      = st.cnt + CNT_ONE;
            next_st.sel_high = sel_lvl;
            if (st.cnt >= POWER_UP_CYC - CNT_ONE) begin
               next_st.state = ST_ARMED;
               next_st.cnt   = CNT_ZERO;
            end
         end
         ST_ARMED: begin
            if (!pressed) begin
               next_st.cnt      = CNT_ZERO;
               next_st.sel_high = sel_lvl;
            end else if (st.cnt >= hold_cyc - CNT_ONE) begin
               next_st.state = ST_ASSERT;
               next_st.cnt   = CNT_ZERO;
               next_st.oe    = 1'b1;
            end else begin
               next_st.cnt = st.cnt + CNT_ONE;
            end
         end
         ST_ASSERT: begin
            if (VARIANT == VAR_LEVEL) begin
               if (!pressed) begin
                  next_st.state = ST_ARMED;
                  next_st.oe    = 1'b0;
                  next_st.sel_high = sel_lvl;
               end
            end else begin
               // inputs are not looked at during the pulse
               next_st.cnt = st.cnt + CNT_ONE;
               if (st.cnt >= PULSE_CYCLES - CNT_ONE) begin
                  next_st.state = ST_SPENT;
                  next_st.cnt   = CNT_ZERO;
                  next_st.oe    = 1'b0;
               end
            end
         end
         ST_SPENT: begin
            if (!pressed) begin
               next_st.state    = ST_ARMED;
               next_st.sel_high = sel_lvl;
            end
         end
         default: begin
            next_st = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign reset_n_out_o = 1'b0;
   assign reset_n_oe_o  = st.oe;

   sequence s_pulse_start;
      $rose(st.oe);
   endsequence

   a_pulse_no_early: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ((VARIANT != VAR_LEVEL) and s_pulse_start) |-> st.oe [*8])
      else $error("fixed pulse ended early");

   a_assert_needs_press: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $rose(st.oe) |-> $past(pressed))
      else $error("reset asserted without press");

   a_level_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (VARIANT == VAR_LEVEL) && st.oe && !pressed |=> !st.oe)
      else $error("level variant did not release");

   a_fixed_release: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (VARIANT != VAR_LEVEL) && st.state == ST_ASSERT && st.cnt == PULSE_CYCLES - CNT_ONE |=> !st.oe)
      else $error("fixed pulse did not end on time");

   a_one_pulse_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $fell(st.oe) && pressed |=> !st.oe)
      else $error("second pulse without release");

   a_hold_cleared: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      st.state == ST_ARMED && !pressed |=> st.cnt == CNT_ZERO)
      else $error("hold timer not cleared");

   a_select_frozen: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      st.state == ST_ARMED && pressed && $past(pressed) |-> $stable(st.sel_high))
      else $error("select changed while timing");

   a_no_drive_startup: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      st.state == ST_POWER_UP |-> !st.oe)
      else $error("output driven during start-up");

   sequence s_armed_release;
      st.state == ST_ARMED && !pressed;
   endsequence

   a_fresh_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_armed_release |=> !st.oe [*8])
      else $error("assert too soon after release");

   a_drive_only_assert: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      st.state != ST_ASSERT |-> !st.oe)
      else $error("output driven outside reset pulse");

   a_spent_waits: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      st.state == ST_SPENT && pressed |=> st.state == ST_SPENT)
      else $error("rearmed without release");

   a_pulse_counts: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (VARIANT != VAR_LEVEL) && st.state == ST_ASSERT && st.cnt != PULSE_CYCLES - CNT_ONE
      |=> st.oe && st.cnt == $past(st.cnt) + CNT_ONE)
      else $error("fixed pulse disturbed");

   a_startup_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      st.state == ST_POWER_UP && st.cnt != POWER_UP_CYC - CNT_ONE |=> st.state == ST_POWER_UP)
      else $error("start-up delay cut short");

   a_select_sampled: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      st.state == ST_ARMED && !pressed |=> st.sel_high == $past(sel_lvl))
      else $error("select not taken while released");

   a_zero_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (VARIANT != VAR_LEVEL) && st.sel_high && st.state == ST_ARMED && pressed
      && st.cnt == ZERO_DETECT_CYC - CNT_ONE |=> st.oe)
      else $error("zero hold did not assert");

   a_level_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (VARIANT == VAR_LEVEL) && st.oe && pressed |=> st.oe)
      else $error("level reset dropped while held");
endmodule : push_button_reset_timer

// >>> pbrt_partner.sv
`timescale 1ns/1ns
module pbrt_partner (
   input  wire logic press_a_i,
   input  wire logic press_b_i,
   input  wire logic reset_n_out_i,
   input  wire logic reset_n_oe_i,
   output logic      button_input_a_o,
   output logic      button_input_b_o,
   output logic      sys_reset_n_o
);
   // a released button sits at the pull-up level, a pressed one pulls low
   assign button_input_a_o = ~press_a_i;
   assign button_input_b_o = ~press_b_i;
   // wired line with an external pull-up
   assign sys_reset_n_o    = reset_n_oe_i ? reset_n_out_i : 1'b1;
endmodule : pbrt_partner

// >>> test_push_button_reset_timer.sv
`timescale 1ns/1ns
module test_push_button_reset_timer;
   import pbrt_pkg::*;
   localparam int HOLD  = 30;
   localparam int PULSE = 20;
   localparam int LAT   = 8;
   localparam int BOOT  = 30000;
   localparam int HOLD_LONG = 50;
   logic ref_clk_i = 1'b0;
   logic rst_i     = 1'b1;
   logic pa        = 1'b1;
   logic pb        = 1'b1;
   logic sel       = 1'b0;
   logic btn_a, btn_b, out_n, oe, sys_n, oe_lvl, oe_one;
   int   error_cnt       = 0;
   int   samples_checked = 0;
   int   n;
   int   m;
   always #5 ref_clk_i = ~ref_clk_i;
   pbrt_partner u_pbrt_partner (.press_a_i(pa), .press_b_i(pb), .reset_n_out_i(out_n), .reset_n_oe_i(oe),
      .button_input_a_o(btn_a), .button_input_b_o(btn_b), .sys_reset_n_o(sys_n));
   push_button_reset_timer #(.VARIANT(VAR_FIXED2), .HOLD_LONG_CYCLES(32'h32), .HOLD_SHORT_CYCLES(32'h1e),
      .PULSE_CYCLES(32'h14)) u_push_button_reset_timer (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .button_input_a_i(btn_a), .button_input_b_i(btn_b), .hold_time_select_i(sel),
      .reset_n_out_o(out_n), .reset_n_oe_o(oe));
   push_button_reset_timer #(.VARIANT(VAR_LEVEL), .HOLD_LONG_CYCLES(32'h32), .HOLD_SHORT_CYCLES(32'h1e),
      .PULSE_CYCLES(32'h14)) u_push_button_reset_timer_level (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .button_input_a_i(btn_a), .button_input_b_i(btn_b), .hold_time_select_i(sel),
      .reset_n_out_o(), .reset_n_oe_o(oe_lvl));
   push_button_reset_timer #(.VARIANT(VAR_FIXED1), .HOLD_LONG_CYCLES(32'h32), .HOLD_SHORT_CYCLES(32'h1e),
      .PULSE_CYCLES(32'h14)) u_push_button_reset_timer_single (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .button_input_a_i(btn_a), .button_input_b_i(btn_b), .hold_time_select_i(sel),
      .reset_n_out_o(), .reset_n_oe_o(oe_one));
   task automatic chk(input bit ok, input string m);
      samples_checked++;
      if (!ok) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic press(input logic a, input logic b);
      @(negedge ref_clk_i);
      pa = a;
      pb = b;
   endtask : press
   task automatic wait_oe(input int lim, output int c);
      c = 0;
      while (oe !== 1'b1 && c < lim) begin
         @(negedge ref_clk_i);
         c++;
      end
   endtask : wait_oe
   task automatic pulse(output int c);
      c = 0;
      while (oe === 1'b1 && c < 1000) begin
         @(negedge ref_clk_i);
         c++;
      end
   endtask : pulse
   task automatic t_power_up;
      repeat (16) @(negedge ref_clk_i);
      rst_i = 1'b0;
      wait_oe(BOOT + 100, n);
      chk(n >= BOOT + HOLD && n <= BOOT + HOLD + LAT, "start-up assert");
      chk(sys_n === 1'b0, "line not low");
      pulse(n);
      chk(n == PULSE, "pulse length");
      chk(sys_n === 1'b1, "line not released");
      wait_oe(100, n);
      chk(n == 100, "second pulse while held");
      press(1'b0, 1'b0);
   endtask : t_power_up
   task automatic t_short;
      repeat (10) @(negedge ref_clk_i);
      press(1'b1, 1'b1);
      wait_oe(20, n);
      chk(n == 20, "short press asserted");
      press(1'b0, 1'b1);
      repeat (3) @(negedge ref_clk_i);
      press(1'b1, 1'b1);
      wait_oe(20, n);
      chk(n == 20 && oe === 1'b0, "timer not cleared");
      press(1'b0, 1'b1);
      wait_oe(100, n);
      chk(n == 100, "one button asserted");
      press(1'b0, 1'b0);
   endtask : t_short
   task automatic t_glitch;
      press(1'b1, 1'b1);
      wait_oe(HOLD + 20, n);
      chk(n >= HOLD && n <= HOLD + LAT, "hold time");
      fork
         pulse(n);
         begin
            repeat (5) @(negedge ref_clk_i);
            press(1'b0, 1'b1);
            repeat (3) @(negedge ref_clk_i);
            press(1'b1, 1'b1);
         end
      join
      chk(n == PULSE, "glitch moved pulse");
      wait_oe(60, n);
      chk(n == 60, "re-assert without release");
   endtask : t_glitch
   task automatic t_rise_in_pulse;
      press(1'b0, 1'b0);
      repeat (10) @(negedge ref_clk_i);
      press(1'b1, 1'b1);
      wait_oe(HOLD + 20, n);
      fork
         pulse(n);
         press(1'b0, 1'b1);
      join
      chk(n == PULSE, "release cut pulse");
      press(1'b1, 1'b1);
      wait_oe(HOLD + 20, n);
      chk(n >= HOLD && n <= HOLD + LAT, "fresh hold after pulse");
      pulse(n);
      press(1'b0, 1'b0);
   endtask : t_rise_in_pulse
   task automatic t_variants;
      press(1'b0, 1'b0);
      repeat (10) @(negedge ref_clk_i);
      press(1'b1, 1'b0);
      n = 0;
      while (oe_one !== 1'b1 && n < HOLD + 20) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(n >= HOLD && n <= HOLD + LAT && oe === 1'b0 && oe_lvl === 1'b0, "single input hold");
      repeat (PULSE - 1) @(negedge ref_clk_i);
      chk(oe_one === 1'b1, "single pulse short");
      repeat (2) @(negedge ref_clk_i);
      chk(oe_one === 1'b0, "single pulse long");
      press(1'b1, 1'b1);
      n = 0;
      while (oe_lvl !== 1'b1 && n < HOLD + 20) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(n >= HOLD && n <= HOLD + LAT && oe === 1'b1 && oe_one === 1'b0, "dual hold");
      repeat (PULSE + 5) @(negedge ref_clk_i);
      chk(oe_lvl === 1'b1 && oe === 1'b0, "level pulse cut short");
      press(1'b1, 1'b0);
      repeat (LAT) @(negedge ref_clk_i);
      chk(oe_lvl === 1'b0, "level not released");
      press(1'b0, 1'b0);
   endtask : t_variants
   task automatic t_select;
      press(1'b0, 1'b0);
      @(negedge ref_clk_i);
      sel = 1'b1;
      repeat (10) @(negedge ref_clk_i);
      press(1'b1, 1'b1);
      n = 0;
      while (oe_lvl !== 1'b1 && n < HOLD_LONG + 20) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(n >= HOLD_LONG && n <= HOLD_LONG + LAT, "long hold");
      wait_oe(15100, m);
      chk(n + m >= 15000 && n + m <= 15000 + LAT && oe_one === 1'b1, "zero hold detect");
      pulse(n);
      press(1'b0, 1'b0);
   endtask : t_select
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   initial begin
      t_power_up();
      t_short();
      t_glitch();
      t_rise_in_pulse();
      t_variants();
      t_select();
      give_verdict();
   end
   initial begin
      #1000000;
      error_cnt++;
      give_verdict();
   end
endmodule : test_push_button_reset_timer
